// ==== src/bod_pkg.sv ====
// Package: register map, field layout and mode codes of the brown-out control block
package bod_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [3:0] MODE_CTRL_OFS   = 4'h0;
  localparam logic [3:0] THRESH_LVL_OFS  = 4'h1;
  localparam logic [3:0] MON_LVL_OFS     = 4'h8;
  localparam logic [3:0] MON_IRQ_CTL_OFS = 4'h9;
  localparam logic [3:0] MON_IRQ_FLG_OFS = 4'hA;
  localparam logic [3:0] MON_STATUS_OFS  = 4'hB;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int SAMPLE_RATE_POS = 4;
  localparam int AWAKE_LO_POS    = 2;
  localparam int SLEEP_LO_POS    = 0;
  localparam int TRIG_LO_POS     = 1;
  localparam int IRQ_EN_POS      = 0;
  localparam int IRQ_FLAG_POS    = 0;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [1:0] MON_LVL_RST  = 2'h0;
  localparam logic [1:0] TRIG_RST     = 2'h0;
  localparam logic       IRQ_EN_RST   = 1'h0;
  localparam logic       IRQ_FLAG_RST = 1'h0;
  localparam logic       STATUS_RST   = 1'h0;
  // ****************************************
  // Mode and trigger codes
  // ****************************************
  localparam logic [1:0] MODE_OFF     = 2'h0;
  localparam logic [1:0] MODE_ON      = 2'h1;
  localparam logic [1:0] MODE_SAMPLED = 2'h2;
  localparam logic [1:0] MODE_ON_WAIT = 2'h3;
  localparam logic [1:0] TRIG_FALL    = 2'h0;
  localparam logic [1:0] TRIG_RISE    = 2'h1;
  localparam logic [1:0] TRIG_BOTH    = 2'h2;
  localparam logic       RATE_1KHZ    = 1'h0;
  localparam logic       RATE_125HZ   = 1'h1;
  localparam logic [1:0] MON_LVL_RSVD = 2'h3;
endpackage

// ==== src/bod_cmp_if.sv ====
// Interface: comparator-side signals shared by the top and the monitor edge unit
`timescale 1ns/1ps
`default_nettype none
interface bod_cmp_if;
  logic       below_raw;
  logic       active;
  logic [1:0] trig_cfg;
  logic       below_sync;
  logic       event_hit;
  modport top (output below_raw, output active, output trig_cfg,
               input below_sync, input event_hit);
  modport mon (input below_raw, input active, input trig_cfg,
               output below_sync, output event_hit);
endinterface
`default_nettype wire

// ==== src/bod_mon_edge.sv ====
// Module: synchroniser and crossing detector for the level monitor comparator
`timescale 1ns/1ps
`default_nettype none
module bod_mon_edge (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  bod_cmp_if.mon    cmp
);
  logic [2:0] sync_r;
  logic       stable_r;
  logic       prev_r;
  logic       agree;
  logic       fell;
  logic       rose;
  logic       hit;

  assign agree = (sync_r[1] == sync_r[2]);
  assign fell  = stable_r & ~prev_r;
  assign rose  = ~stable_r & prev_r;
  // Falling supply means below goes high
  assign hit   = cmp.active & (((cmp.trig_cfg == bod_pkg::TRIG_FALL) & fell) |
                               ((cmp.trig_cfg == bod_pkg::TRIG_RISE) & rose) |
                               ((cmp.trig_cfg == bod_pkg::TRIG_BOTH) & (fell | rose)));
  assign cmp.below_sync = stable_r;
  assign cmp.event_hit  = hit;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      sync_r   <= 3'h0;
      stable_r <= bod_pkg::STATUS_RST;
      prev_r   <= bod_pkg::STATUS_RST;
    end else begin
      sync_r   <= {sync_r[1:0], cmp.below_raw};
      stable_r <= agree ? sync_r[2] : stable_r;
      prev_r   <= stable_r;
    end
  end
endmodule
`default_nettype wire

// ==== src/bod_ctrl.sv ====
// Module: brown-out detector and level monitor control and status registers
//
// Function
// - Rate bit: 0 is 1 kHz, 1 is 125 Hz
// - Rate loaded from fuse, protected write only
// - Awake field selects active and idle mode
// - Mode 3 holds wake-up until detector ready
// - Awake field fuse loaded, software read-only
// - Sleep field selects standby mode, 3 reserved
// - Sleep field fuse loaded, protected write only
// - Trip level fuse loaded, read-only, eight codes
// - Monitor offset five, fifteen, twenty-five percent
// - Trigger field selects falling, rising or both
// - Enable bit gates monitor interrupt request
// - Matching crossing sets the monitor flag while enable bit set
// - Flag updates only while detector enabled
// - Status reads one while supply below threshold
// - Request high while enable and flag set
// - Monitor enabled only while detector enabled and enable bit set
// - Sleep entry uses sleep field, wake awake
`timescale 1ns/1ps
`default_nettype none
module bod_ctrl (
  // Clock and reset
  input  wire logic       SYS_CLK_IN,
  input  wire logic       NRST_IN,
  // Register port
  input  wire logic [3:0] ADDR_IN,
  input  wire logic [7:0] WDATA_IN,
  input  wire logic       WR_IN,
  input  wire logic       RD_IN,
  output logic      [7:0] RDATA_OUT,
  // Protection unlock window from the CPU
  input  wire logic       CFG_UNLOCK_IN,
  // Fuse values captured at reset release
  input  wire logic       FUSE_RATE_IN,
  input  wire logic [1:0] FUSE_AWAKE_IN,
  input  wire logic [1:0] FUSE_SLEEP_IN,
  input  wire logic [2:0] FUSE_LEVEL_IN,
  // Power state and analog side
  input  wire logic       DEEP_SLEEP_IN,
  input  wire logic       DET_READY_IN,
  input  wire logic       MON_BELOW_IN,
  // Analog control outputs
  output logic      [1:0] DET_MODE_OUT,
  output logic            DET_ENABLE_OUT,
  output logic            DET_SAMPLED_OUT,
  output logic            SAMPLE_RATE_OUT,
  output logic      [2:0] TRIP_LEVEL_OUT,
  output logic      [1:0] MON_OFFSET_OUT,
  output logic            MON_ENABLE_OUT,
  // System side
  output logic            WAKE_HOLD_OUT,
  output logic            MON_IRQ_OUT
);
  // ****************************************
  // Storage
  // ****************************************
  logic       fuse_pend_r;
  logic       rate_r;
  logic [1:0] awake_r;
  logic [1:0] sleep_r;
  logic [2:0] level_r;
  logic [1:0] mon_lvl_r;
  logic [1:0] trig_r;
  logic       irq_en_r;
  logic       flag_r;
  logic       flag_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  bod_cmp_if cmp ();

  // ****************************************
  // Decode
  // ****************************************
  function automatic logic hit_wr(input logic [3:0] a, input logic [3:0] ofs,
                                  input logic we);
    hit_wr = we & (a == ofs);
  endfunction

  logic       wr_mode;
  logic       wr_mon_lvl;
  logic       wr_irq_ctl;
  logic       wr_flag;
  logic       prot_ok;
  logic [1:0] cur_mode;
  logic       det_on;
  logic       det_smp;
  logic       mon_act;
  logic       flag_clr;

  assign wr_mode    = hit_wr(ADDR_IN, bod_pkg::MODE_CTRL_OFS, WR_IN);
  assign wr_mon_lvl = hit_wr(ADDR_IN, bod_pkg::MON_LVL_OFS, WR_IN);
  assign wr_irq_ctl = hit_wr(ADDR_IN, bod_pkg::MON_IRQ_CTL_OFS, WR_IN);
  assign wr_flag    = hit_wr(ADDR_IN, bod_pkg::MON_IRQ_FLG_OFS, WR_IN);
  assign prot_ok    = wr_mode & CFG_UNLOCK_IN;

  // ****************************************
  // Mode selection
  // ****************************************
  assign cur_mode = DEEP_SLEEP_IN ? sleep_r : awake_r;
  assign det_on   = (cur_mode == bod_pkg::MODE_ON) |
                    (cur_mode == bod_pkg::MODE_SAMPLED) |
                    (!DEEP_SLEEP_IN & (cur_mode == bod_pkg::MODE_ON_WAIT));
  assign det_smp  = (cur_mode == bod_pkg::MODE_SAMPLED);
  assign mon_act  = det_on & irq_en_r;

  assign cmp.below_raw = MON_BELOW_IN;
  assign cmp.active    = mon_act;
  assign cmp.trig_cfg  = trig_r;

  bod_mon_edge u_edge (
    .clk_in  (SYS_CLK_IN),
    .nrst_in (NRST_IN),
    .cmp     (cmp)
  );

  // ****************************************
  // Flag
  // ****************************************
  assign flag_clr = wr_flag & WDATA_IN[bod_pkg::IRQ_FLAG_POS];
  // Set wins over a clear in the same cycle; frozen while detector off
  assign flag_nxt = !det_on ? flag_r :
                    cmp.event_hit ? 1'b1 :
                    flag_clr ? 1'b0 : flag_r;

  // ****************************************
  // Read mux
  // ****************************************
  always_comb begin
    rdata_nxt = 8'h00;
    if (RD_IN) begin
      unique case (ADDR_IN)
        bod_pkg::MODE_CTRL_OFS:   rdata_nxt = {3'h0, rate_r, awake_r, sleep_r};
        bod_pkg::THRESH_LVL_OFS:  rdata_nxt = {5'h00, level_r};
        bod_pkg::MON_LVL_OFS:     rdata_nxt = {6'h00, mon_lvl_r};
        bod_pkg::MON_IRQ_CTL_OFS: rdata_nxt = {5'h00, trig_r, irq_en_r};
        bod_pkg::MON_IRQ_FLG_OFS: rdata_nxt = {7'h00, flag_r};
        bod_pkg::MON_STATUS_OFS:  rdata_nxt = {7'h00, cmp.below_sync};
        default:                  rdata_nxt = 8'h00;
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge SYS_CLK_IN) begin
    if (!NRST_IN) begin
      fuse_pend_r <= 1'b1;
      rate_r      <= bod_pkg::RATE_1KHZ;
      awake_r     <= bod_pkg::MODE_OFF;
      sleep_r     <= bod_pkg::MODE_OFF;
      level_r     <= 3'h0;
    end else if (fuse_pend_r) begin
      fuse_pend_r <= 1'b0;
      rate_r      <= FUSE_RATE_IN;
      awake_r     <= FUSE_AWAKE_IN;
      sleep_r     <= FUSE_SLEEP_IN;
      level_r     <= FUSE_LEVEL_IN;
    end else if (prot_ok) begin
      rate_r      <= WDATA_IN[bod_pkg::SAMPLE_RATE_POS];
      sleep_r     <= WDATA_IN[bod_pkg::SLEEP_LO_POS +: 2];
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!NRST_IN) begin
      mon_lvl_r <= bod_pkg::MON_LVL_RST;
      trig_r    <= bod_pkg::TRIG_RST;
      irq_en_r  <= bod_pkg::IRQ_EN_RST;
      flag_r    <= bod_pkg::IRQ_FLAG_RST;
      rdata_r   <= 8'h00;
    end else begin
      if (wr_mon_lvl) begin
        mon_lvl_r <= WDATA_IN[1:0];
      end
      if (wr_irq_ctl) begin
        trig_r   <= WDATA_IN[bod_pkg::TRIG_LO_POS +: 2];
        irq_en_r <= WDATA_IN[bod_pkg::IRQ_EN_POS];
      end
      flag_r  <= flag_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign RDATA_OUT       = rdata_r;
  assign DET_MODE_OUT    = cur_mode;
  assign DET_ENABLE_OUT  = det_on;
  assign DET_SAMPLED_OUT = det_smp;
  assign SAMPLE_RATE_OUT = rate_r;
  assign TRIP_LEVEL_OUT  = level_r;
  assign MON_OFFSET_OUT  = mon_lvl_r;
  assign MON_ENABLE_OUT  = mon_act;
  assign WAKE_HOLD_OUT   = (awake_r == bod_pkg::MODE_ON_WAIT) & !DET_READY_IN;
  assign MON_IRQ_OUT     = irq_en_r & flag_r;
endmodule
`default_nettype wire

// ==== verif/bod_analog_model.sv ====
// Model of the analog side: supply comparator and detector ready
`timescale 1ns/1ps
`default_nettype none
module bod_analog_model (
  // Clock and controls
  input  wire logic clk_in,
  input  wire logic det_enable_in,
  input  wire logic supply_low_in,
  // Comparator outputs
  output logic      below_out,
  output logic      ready_out
);
  logic [2:0] settle_r = 3'h0;
  logic       toggle_r = 1'b0;
  // Ready only after the detector has run a few cycles
  always_ff @(posedge clk_in) begin
    settle_r <= det_enable_in ? settle_r + {2'h0, settle_r != 3'h4} : 3'h0;
    toggle_r <= ~toggle_r;
  end
  assign ready_out = settle_r == 3'h4;
  // Comparator output is meaningless while the detector is off
  assign below_out = det_enable_in ? supply_low_in : toggle_r;
endmodule
`default_nettype wire

// ==== verif/bod_ctrl_sva.sv ====
// Checker: port-level properties of the brown-out control block
`timescale 1ns/1ps
`default_nettype none
module bod_ctrl_sva (
  // Clock, reset and register port
  input wire logic       SYS_CLK_IN,
  input wire logic       NRST_IN,
  input wire logic [3:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic       WR_IN,
  input wire logic       RD_IN,
  input wire logic [7:0] RDATA_OUT,
  input wire logic       CFG_UNLOCK_IN,
  // Power state and outputs
  input wire logic       DEEP_SLEEP_IN,
  input wire logic       DET_READY_IN,
  input wire logic [1:0] DET_MODE_OUT,
  input wire logic       DET_ENABLE_OUT,
  input wire logic       DET_SAMPLED_OUT,
  input wire logic       SAMPLE_RATE_OUT,
  input wire logic [2:0] TRIP_LEVEL_OUT,
  input wire logic [1:0] MON_OFFSET_OUT,
  input wire logic       MON_ENABLE_OUT,
  input wire logic       WAKE_HOLD_OUT,
  input wire logic       MON_IRQ_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!NRST_IN);
  wire logic wr_mode = WR_IN && ADDR_IN == bod_pkg::MODE_CTRL_OFS;
  wire logic wr_ctl  = WR_IN && ADDR_IN == bod_pkg::MON_IRQ_CTL_OFS;
  wire logic wr_flg  = WR_IN && ADDR_IN == bod_pkg::MON_IRQ_FLG_OFS;
  wire logic on_mode = DET_MODE_OUT == bod_pkg::MODE_ON || DET_MODE_OUT == bod_pkg::MODE_SAMPLED;
  rate_write_a: assert property (wr_mode && CFG_UNLOCK_IN |=>
    SAMPLE_RATE_OUT == $past(WDATA_IN[4])) else $error("rate bit not written");
  rate_lock_a: assert property (wr_mode && !CFG_UNLOCK_IN |=>
    $stable(SAMPLE_RATE_OUT)) else $error("locked write changed rate");
  sampled_mode_a: assert property (DET_SAMPLED_OUT ==
    (DET_MODE_OUT == bod_pkg::MODE_SAMPLED)) else $error("sampled flag wrong");
  det_enable_a: assert property (DET_ENABLE_OUT == (on_mode ||
    (DET_MODE_OUT == bod_pkg::MODE_ON_WAIT && !DEEP_SLEEP_IN))) else $error("enable wrong");
  wake_hold_a: assert property (!DEEP_SLEEP_IN |-> WAKE_HOLD_OUT ==
    (DET_MODE_OUT == bod_pkg::MODE_ON_WAIT && !DET_READY_IN)) else $error("wake hold wrong");
  mon_enable_a: assert property (MON_ENABLE_OUT |-> DET_ENABLE_OUT)
    else $error("monitor on with detector off");
  irq_hold_a: assert property (MON_IRQ_OUT && !wr_ctl && !wr_flg |=> MON_IRQ_OUT)
    else $error("request dropped");
  flag_frozen_a: assert property (!DET_ENABLE_OUT && !wr_ctl |=>
    $stable(MON_IRQ_OUT)) else $error("flag moved with detector off");
  trip_read_a: assert property (RD_IN && ADDR_IN == bod_pkg::THRESH_LVL_OFS |=>
    RDATA_OUT == {5'h00, TRIP_LEVEL_OUT}) else $error("trip level read wrong");
  offset_read_a: assert property (RD_IN && ADDR_IN == bod_pkg::MON_LVL_OFS |=>
    RDATA_OUT == {6'h00, MON_OFFSET_OUT}) else $error("offset read wrong");
endmodule
bind bod_ctrl bod_ctrl_sva chk_u (.*);
`default_nettype wire

// ==== verif/bod_ctrl_bench.sv ====
// Testbench: register, mode and monitor scenarios of the brown-out control block
`timescale 1ns/1ps
`default_nettype none
module brownout_and_level_monitor_regs_bench;
  logic       clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, unl = 1'b0, slp = 1'b0, blw = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [7:0] wd  = 8'h00;
  logic [1:0] fa  = 2'h0;
  wire logic [7:0] rdo;
  wire logic [1:0] dmode, moff;
  wire logic [2:0] tlvl;
  wire logic       den, dsmp, srate, men, whold, irq, mb, rdy;
  int bad_count = 0, cmp_count = 0, cyc = 0;
  bod_ctrl dut_u (.SYS_CLK_IN(clk), .NRST_IN(nrst), .ADDR_IN(adr), .WDATA_IN(wd), .WR_IN(wr),
    .RD_IN(rd), .RDATA_OUT(rdo), .CFG_UNLOCK_IN(unl), .FUSE_RATE_IN(1'h1), .FUSE_AWAKE_IN(fa),
    .FUSE_SLEEP_IN(2'h2), .FUSE_LEVEL_IN(3'h5), .DEEP_SLEEP_IN(slp), .DET_READY_IN(rdy),
    .MON_BELOW_IN(mb), .DET_MODE_OUT(dmode), .DET_ENABLE_OUT(den), .DET_SAMPLED_OUT(dsmp),
    .SAMPLE_RATE_OUT(srate), .TRIP_LEVEL_OUT(tlvl), .MON_OFFSET_OUT(moff),
    .MON_ENABLE_OUT(men), .WAKE_HOLD_OUT(whold), .MON_IRQ_OUT(irq));
  bod_analog_model ana_u (.clk_in(clk), .det_enable_in(den), .supply_low_in(blw),
    .below_out(mb), .ready_out(rdy));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic stop_test();
    if (bad_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wrt(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    adr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    adr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdo, e);
  endtask
  task automatic rst(input logic [1:0] a);
    @(posedge clk);
    nrst <= 1'b0;
    fa <= a;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({6'h00, dmode}, {6'h00, a});
    chk({6'h00, den, dsmp}, {6'h00, a != 2'h0, a == 2'h2});
    chk({7'h00, whold}, {7'h00, a == 2'h3});
    repeat (8) @(posedge clk);
    chk({7'h00, whold}, 8'h00);
  endtask
  initial begin
    for (int a = 0; a < 4; a++)
      rst(a[1:0]);
    rdc(4'h0, 8'h1E);
    rdc(4'h1, 8'h05);
    chk({5'h00, tlvl}, 8'h05);
    rdc(4'h4, 8'h00);
    wrt(4'h0, 8'hFF);
    rdc(4'h0, 8'h1E);
    unl <= 1'b1;
    wrt(4'h0, 8'hE1);
    rdc(4'h0, 8'h0D);
    chk({7'h00, srate}, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wrt(4'h0, {6'h00, s[1:0]});
      slp <= 1'b1;
      @(posedge clk);
      #1;
      chk({6'h00, dmode}, {6'h00, s[1:0]});
      chk({7'h00, den}, {7'h00, s == 1 || s == 2});
      slp <= 1'b0;
    end
    wrt(4'h0, 8'h01);
    wrt(4'h8, 8'hFF);
    rdc(4'h8, 8'h03);
    chk({6'h00, moff}, 8'h03);
    wrt(4'hB, 8'hFF);
    rdc(4'hB, 8'h00);
    for (int t = 0; t < 4; t++) begin
      wrt(4'h9, {5'h00, t[1:0], 1'b1});
      rdc(4'h9, {5'h00, t[1:0], 1'b1});
      chk({7'h00, men}, 8'h01);
      blw <= 1'b1;
      repeat (8) @(posedge clk);
      rdc(4'hB, 8'h01);
      rdc(4'hA, {7'h00, t == 0 || t == 2});
      chk({7'h00, irq}, {7'h00, t == 0 || t == 2});
      wrt(4'hA, 8'h01);
      blw <= 1'b0;
      repeat (8) @(posedge clk);
      rdc(4'hB, 8'h00);
      rdc(4'hA, {7'h00, t == 1 || t == 2});
      wrt(4'hA, 8'h01);
    end
    wrt(4'h9, 8'h05);
    blw <= 1'b1;
    repeat (8) @(posedge clk);
    wrt(4'h9, 8'h04);
    chk({7'h00, irq}, 8'h00);
    chk({7'h00, men}, 8'h00);
    wrt(4'h9, 8'h05);
    wrt(4'hA, 8'h00);
    rdc(4'hA, 8'h01);
    wrt(4'h0, 8'h00);
    slp <= 1'b1;
    wrt(4'hA, 8'h01);
    rdc(4'hA, 8'h01);
    chk({7'h00, men}, 8'h00);
    slp <= 1'b0;
    repeat (8) @(posedge clk);
    wrt(4'hA, 8'h01);
    rdc(4'hA, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
